// [design/thz_monitor.sv]
// Operation
// - Pulse the sense current source at 1 kHz with equal on and off halves.
// - Convert the sense pin voltage and derive the zone code from the result.
// - Zone code is thermometer coded from pin voltage, FFh at 0.88 V down to 00h.
// - Zone bit 6 rising sets status bit 1 and asserts the alert line on the same edge.
// - A status read after an alert releases the alert line.
// - Zone bit 7 rising asserts the active-low throttle output.
// - Throttle output releases only when zone bit 6 falls.
// - Zone bit 5 falling clears status bit 1 and asserts the alert again.
//
// The address map and register access over Avalon-MM were left to the implementer.
`timescale 1ns/100ps
`default_nettype none

module thz_monitor #(
    parameter int unsigned HALF_CYCLES   = thz_pkg::SRC_HALF_CYCLES,
    parameter int unsigned SETTLE_CYCLES = thz_pkg::SETTLE_CYCLES
) (
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic [4:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output var  logic [31:0] avs_readdata,
    output var  logic        avs_waitrequest,
    output var  logic        ntcSourceEn,
    output var  logic        adcStart,
    input  wire logic        adcDone,
    input  wire logic [7:0]  adcCode,
    output var  logic        alertN,
    output var  logic        thermalThrottleN,
    output var  logic        irq
);

    if (SETTLE_CYCLES < 1 || SETTLE_CYCLES + 2 >= HALF_CYCLES)
    begin : g_badTiming
        $error("thz_monitor: settle time must fit inside the on half");
    end

    // ----------------------------------------------------------------
    // Input synchronisers
    // ----------------------------------------------------------------
    logic       doneSync;
    logic       doneSyncD;
    logic [7:0] codeSync;

    thz_sync #(.WIDTH(1)) u_doneSync (
        .clk     (core_clk),
        .rst     (rst),
        .asyncIn (adcDone),
        .syncOut (doneSync)
    );

    thz_sync #(.WIDTH(8)) u_codeSync (
        .clk     (core_clk),
        .rst     (rst),
        .asyncIn (adcCode),
        .syncOut (codeSync)
    );

    always_ff @(posedge core_clk)
    begin
        if (rst)
            doneSyncD <= 1'b0;
        else
            doneSyncD <= doneSync;
    end

    logic doneRise;
    assign doneRise = doneSync & ~doneSyncD;

    // ----------------------------------------------------------------
    // Register state
    // ----------------------------------------------------------------
    logic                monEnable;
    logic [7:0]          thermalZoneCode;
    logic                hotFlag;
    logic [3:0]          evtStatus;
    logic [3:0]          evtMask;
    thz_pkg::thz_evt_s   evt;

    // ----------------------------------------------------------------
    // Current source pulsing
    // ----------------------------------------------------------------
    logic [31:0] phaseCnt;
    logic        phaseEnd;
    assign phaseEnd = (phaseCnt == 32'(HALF_CYCLES - 1));

    always_ff @(posedge core_clk)
    begin
        if (rst || !monEnable)
        begin
            phaseCnt    <= '0;
            ntcSourceEn <= 1'b0;
        end
        else if (phaseEnd)
        begin
            phaseCnt    <= '0;
            ntcSourceEn <= ~ntcSourceEn;
        end
        else
        begin
            phaseCnt <= phaseCnt + 32'h1;
        end
    end

    // ----------------------------------------------------------------
    // Conversion sequencing
    // ----------------------------------------------------------------
    thz_pkg::thz_conv_e convState;
    logic               startNow;
    assign startNow = (convState == thz_pkg::CV_SETTLE) && ntcSourceEn
                      && (phaseCnt == 32'(SETTLE_CYCLES));

    // A conversion that outlives the on half still completes; the source
    // restarts before the next result, so the zone rate never exceeds 1 kHz.
    always_ff @(posedge core_clk)
    begin
        if (rst || !monEnable)
        begin
            convState <= thz_pkg::CV_IDLE;
            adcStart  <= 1'b0;
        end
        else
        begin
            adcStart <= startNow;
            unique case (convState)
                thz_pkg::CV_IDLE:
                    if (ntcSourceEn)
                        convState <= thz_pkg::CV_SETTLE;
                thz_pkg::CV_SETTLE:
                    if (startNow)
                        convState <= thz_pkg::CV_CONV;
                thz_pkg::CV_CONV:
                    if (doneRise)
                        convState <= thz_pkg::CV_HELD;
                thz_pkg::CV_HELD:
                    if (!ntcSourceEn)
                        convState <= thz_pkg::CV_IDLE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Zone code
    // ----------------------------------------------------------------
    logic [7:0] nextZone;
    genvar      gi;
    generate
        for (gi = 0; gi < 8; gi++)
        begin : g_zone
            assign nextZone[gi] = (codeSync <= thz_pkg::ZONE_LIMITS[gi*8 +: 8]);
        end
    endgenerate

    logic zoneLoad;
    assign zoneLoad = (convState == thz_pkg::CV_CONV) && doneRise;

    always_ff @(posedge core_clk)
    begin
        if (rst)
            thermalZoneCode <= thz_pkg::ZONE_RESET;
        else if (zoneLoad)
            thermalZoneCode <= nextZone;
    end

    always_comb
    begin
        evt        = '0;
        evt.hotSet = zoneLoad && !thermalZoneCode[thz_pkg::ZONE_ALERT_BIT]
                     && nextZone[thz_pkg::ZONE_ALERT_BIT];
        evt.hotClr = zoneLoad && thermalZoneCode[thz_pkg::ZONE_RELEASE_BIT]
                     && !nextZone[thz_pkg::ZONE_RELEASE_BIT];
        evt.thrOn  = zoneLoad && !thermalZoneCode[thz_pkg::ZONE_THROTTLE_BIT]
                     && nextZone[thz_pkg::ZONE_THROTTLE_BIT];
        evt.thrOff = zoneLoad && thermalZoneCode[thz_pkg::ZONE_ALERT_BIT]
                     && !nextZone[thz_pkg::ZONE_ALERT_BIT];
    end

    // ----------------------------------------------------------------
    // Throttle output
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (rst)
            thermalThrottleN <= 1'b1;
        else if (evt.thrOn)
            thermalThrottleN <= 1'b0;
        else if (evt.thrOff)
            thermalThrottleN <= 1'b1;
    end

    // ----------------------------------------------------------------
    // Status flag and alert line
    // ----------------------------------------------------------------
    logic busDone;
    logic statusRead;
    assign busDone    = (avs_read || avs_write) && !avs_waitrequest;
    assign statusRead = busDone && avs_read && (avs_address == thz_pkg::OFF_STATUS);

    always_ff @(posedge core_clk)
    begin
        if (rst)
            hotFlag <= 1'b0;
        else if (evt.hotSet)
            hotFlag <= 1'b1;
        else if (evt.hotClr)
            hotFlag <= 1'b0;
    end

    // The alert falls on the edge that updates the flag, so the host never sees
    // the alert before the status that explains it. A new event wins over a read.
    always_ff @(posedge core_clk)
    begin
        if (rst)
            alertN <= 1'b1;
        else if (evt.hotSet || evt.hotClr)
            alertN <= 1'b0;
        else if (statusRead)
            alertN <= 1'b1;
    end

    // ----------------------------------------------------------------
    // Event status, mask and interrupt
    // ----------------------------------------------------------------
    logic writeLow;
    assign writeLow = busDone && avs_write && avs_byteenable[0];

    always_ff @(posedge core_clk)
    begin
        if (rst)
            evtStatus <= thz_pkg::EVENT_RESET;
        else if (writeLow && avs_address == thz_pkg::OFF_EVENT)
            evtStatus <= (evtStatus & ~avs_writedata[3:0]) | evt;
        else
            evtStatus <= evtStatus | evt;
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            evtMask   <= thz_pkg::MASK_RESET;
            monEnable <= thz_pkg::CTRL_EN_RESET;
        end
        else if (writeLow)
        begin
            if (avs_address == thz_pkg::OFF_MASK)
                evtMask <= avs_writedata[3:0];
            if (avs_address == thz_pkg::OFF_CTRL)
                monEnable <= avs_writedata[thz_pkg::CTRL_EN_BIT];
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
            irq <= 1'b0;
        else
            irq <= |(evtStatus & evtMask);
    end

    // ----------------------------------------------------------------
    // Avalon slave: one wait state, then the answer
    // ----------------------------------------------------------------
    logic [31:0] next_readdata;

    always_comb
    begin
        next_readdata = '0;
        unique case (avs_address)
            thz_pkg::OFF_ZONE:   next_readdata[7:0] = thermalZoneCode;
            thz_pkg::OFF_STATUS: next_readdata[thz_pkg::STATUS_HOT_BIT] = hotFlag;
            thz_pkg::OFF_EVENT:  next_readdata[3:0] = evtStatus;
            thz_pkg::OFF_MASK:   next_readdata[3:0] = evtMask;
            thz_pkg::OFF_CTRL:   next_readdata[thz_pkg::CTRL_EN_BIT] = monEnable;
            default:             next_readdata = '0;
        endcase
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            avs_waitrequest <= 1'b1;
            avs_readdata    <= '0;
        end
        else
        begin
            avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
            if (avs_read && avs_waitrequest)
                avs_readdata <= next_readdata;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    sequence s_hotRise;
        zoneLoad && !thermalZoneCode[6] && nextZone[6];
    endsequence

    sequence s_flagThenAlert;
        hotFlag && !alertN;
    endsequence

    source_toggle_a: assert property (monEnable && phaseEnd && $past(monEnable)
        |=> ntcSourceEn != $past(ntcSourceEn))
        else $error("source did not toggle at half period");
    source_hold_a: assert property (monEnable && !phaseEnd |=> $stable(ntcSourceEn)
        || !monEnable)
        else $error("source changed mid half");
    zone_load_a: assert property (zoneLoad |=> thermalZoneCode == $past(nextZone))
        else $error("zone code not taken from conversion");
    zone_code_a: assert property (zoneLoad && codeSync == 8'h58 |=> thermalZoneCode == 8'hff)
        else $error("zone code wrong at lowest limit");
    alert_raise_a: assert property (s_hotRise |=> s_flagThenAlert)
        else $error("alert rise sequence broken");
    alert_release_a: assert property (statusRead && !evt.hotSet && !evt.hotClr |=> alertN)
        else $error("alert not released after status read");
    throttle_on_a: assert property (evt.thrOn |=> !thermalThrottleN)
        else $error("throttle not asserted");
    throttle_off_a: assert property ($rose(thermalThrottleN) |-> $past(evt.thrOff))
        else $error("throttle released without bit 6 fall");
    alert_clear_a: assert property (evt.hotClr |=> !hotFlag && !alertN)
        else $error("status not cleared on bit 5 fall");
    sample_on_a: assert property ($rose(adcStart) |-> ntcSourceEn
        && phaseCnt == 32'(SETTLE_CYCLES) + 32'h1)
        else $error("conversion started outside settled on time");

endmodule

`default_nettype wire

// [design/thz_pkg.sv]
package thz_pkg;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS   = 25;
    localparam int unsigned SRC_PERIOD_NS   = 1000000;
    localparam int unsigned SRC_HALF_CYCLES = SRC_PERIOD_NS / 2 / CLK_PERIOD_NS;
    localparam int unsigned SETTLE_NS       = 100000;
    localparam int unsigned SETTLE_CYCLES   = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ----------------------------------------------------------------
    // Converter and zone code
    // ----------------------------------------------------------------
    localparam int unsigned ADC_W   = 8;
    localparam int unsigned ZONE_W  = 8;
    // Pin voltage limits in 10 mV units, bit 7 first: a zone bit is set
    // while the sensed voltage is at or below its limit.
    localparam logic [63:0] ZONE_LIMITS =
        {8'h58, 8'h5c, 8'h60, 8'h64, 8'h68, 8'h6c, 8'h70, 8'h78};
    localparam int unsigned ZONE_THROTTLE_BIT = 7;
    localparam int unsigned ZONE_ALERT_BIT    = 6;
    localparam int unsigned ZONE_RELEASE_BIT  = 5;
    localparam logic [7:0]  ZONE_RESET        = 8'h00;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam int unsigned ADDR_W      = 5;
    localparam logic [4:0]  OFF_ZONE    = 5'h00;
    localparam logic [4:0]  OFF_STATUS  = 5'h04;
    localparam logic [4:0]  OFF_EVENT   = 5'h08;
    localparam logic [4:0]  OFF_MASK    = 5'h0c;
    localparam logic [4:0]  OFF_CTRL    = 5'h10;
    localparam int unsigned STATUS_HOT_BIT = 1;
    localparam int unsigned CTRL_EN_BIT    = 0;
    localparam logic        CTRL_EN_RESET  = 1'b1;
    localparam logic [3:0]  MASK_RESET     = 4'h0;
    localparam logic [3:0]  EVENT_RESET    = 4'h0;

    typedef struct packed {
        logic thrOff;
        logic thrOn;
        logic hotClr;
        logic hotSet;
    } thz_evt_s;

    typedef enum logic [1:0] {
        CV_IDLE   = 2'h0,
        CV_SETTLE = 2'h1,
        CV_CONV   = 2'h3,
        CV_HELD   = 2'h2
    } thz_conv_e;

endpackage

// [design/thz_sync.sv]
`timescale 1ns/100ps
`default_nettype none

module thz_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] asyncIn,
    output var  logic [WIDTH-1:0] syncOut
);

    logic [WIDTH-1:0] stage1;

    if (WIDTH < 1)
    begin : g_badWidth
        $error("thz_sync: WIDTH must be at least 1");
    end

    // The first stage may go metastable, so only the second stage reads it.
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            stage1  <= '0;
            syncOut <= '0;
        end
        else
        begin
            stage1  <= asyncIn;
            syncOut <= stage1;
        end
    end

endmodule

`default_nettype wire

// [tb/tb_thermal_zone_alert_monitor.sv]
`timescale 1ns/100ps
`default_nettype none

module tb_thermal_zone_alert_monitor;
    localparam int unsigned HALF   = 40;
    localparam int unsigned SETTLE = 8;
    localparam logic [7:0] VIN  [11] = '{8'h79, 8'h78, 8'h74, 8'h70, 8'h6c, 8'h68,
                                          8'h64, 8'h60, 8'h5c, 8'h58, 8'h54};
    localparam logic [7:0] ZONE [11] = '{8'h00, 8'h01, 8'h01, 8'h03, 8'h07, 8'h0f,
                                          8'h1f, 8'h3f, 8'h7f, 8'hff, 8'hff};
    localparam logic [1:0] FLG  [11] = '{2'h3, 2'h3, 2'h3, 2'h3, 2'h3, 2'h3,
                                          2'h3, 2'h3, 2'h1, 2'h0, 2'h0};

    logic        core_clk;
    logic        rst;
    logic [4:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [3:0]  avs_byteenable;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        ntcSourceEn;
    logic        adcStart;
    logic        adcDone;
    logic [7:0]  adcCode;
    logic        alertN;
    logic        thermalThrottleN;
    logic        irq;
    logic [7:0]  pinCode;
    logic        slowAdc;
    logic [31:0] rdata;
    int          failCount;
    int          checks;
    int          n;

    thz_monitor #(.HALF_CYCLES(HALF), .SETTLE_CYCLES(SETTLE)) uut (
        .core_clk(core_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .ntcSourceEn(ntcSourceEn), .adcStart(adcStart),
        .adcDone(adcDone), .adcCode(adcCode), .alertN(alertN),
        .thermalThrottleN(thermalThrottleN), .irq(irq));

    thz_adc_model adc (
        .core_clk(core_clk), .ntcSourceEn(ntcSourceEn), .adcStart(adcStart),
        .pinCode(pinCode), .slowAdc(slowAdc), .adcDone(adcDone), .adcCode(adcCode));

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp)
        begin
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
            failCount++;
        end
    endtask

    task automatic give_verdict;
        $display("Checks %0d mismatches %0d", checks, failCount);
        if (failCount == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // One idle edge before each request keeps every signal to one change per step.
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] wd,
                       input logic [3:0] be);
        int k;
        @(posedge core_clk);
        avs_address    <= a;
        avs_writedata  <= wd;
        avs_byteenable <= be;
        avs_write      <= wr;
        avs_read       <= !wr;
        k = 0;
        do
        begin
            @(posedge core_clk);
            k++;
        end
        while (avs_waitrequest !== 1'b0 && k < 50);
        rdata = avs_readdata;
        if (k >= 50)
            chk("bus answer", 32'h0, 32'h1);
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic conv(input logic [7:0] v);
        int k;
        pinCode <= v;
        k = 0;
        do
        begin
            @(posedge core_clk);
            k++;
        end
        while (adcStart !== 1'b1 && k < 200);
        repeat (30) @(posedge core_clk);
    endtask

    always @(posedge core_clk)
        if (!rst && adcStart === 1'b1)
            chk("source on at sample", 32'h1, 32'(ntcSourceEn));

    initial
    begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    initial
    begin
        repeat (20000) @(posedge core_clk);
        failCount++;
        give_verdict();
    end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial
    begin
        rst = 1'b1; avs_address = 5'h00; avs_read = 1'b0; avs_write = 1'b0;
        avs_writedata = 32'h0; avs_byteenable = 4'hf; pinCode = 8'h79; slowAdc = 1'b0;
        failCount = 0; checks = 0;
        repeat (3) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        chk("alert at reset", 32'h1, 32'(alertN));
        bus(1'b0, thz_pkg::OFF_CTRL, 32'h0, 4'hf);
        chk("ctrl reset", 32'h1, rdata);
        n = 0;
        while (ntcSourceEn !== 1'b1 && n < 200) begin @(posedge core_clk); n++; end
        n = 0;
        while (ntcSourceEn === 1'b1 && n < 200) begin @(posedge core_clk); n++; end
        chk("source on time", 32'(HALF), 32'(n));
        n = 0;
        while (ntcSourceEn !== 1'b1 && n < 200) begin @(posedge core_clk); n++; end
        chk("source off time", 32'(HALF), 32'(n));
        for (int i = 0; i < 11; i++)
        begin
            slowAdc <= i[0];
            conv(VIN[i]);
            bus(1'b0, thz_pkg::OFF_ZONE, 32'h0, 4'hf);
            chk("zone code", {24'h0, ZONE[i]}, rdata);
            chk("alert line", 32'(FLG[i][1]), 32'(alertN));
            chk("throttle", 32'(FLG[i][0]), 32'(thermalThrottleN));
        end
        chk("masked irq", 32'h0, 32'(irq));
        bus(1'b0, thz_pkg::OFF_STATUS, 32'h0, 4'hf);
        chk("status hot", 32'h2, rdata);
        repeat (2) @(posedge core_clk);
        chk("alert released", 32'h1, 32'(alertN));
        conv(8'h5c);
        chk("throttle held", 32'h0, 32'(thermalThrottleN));
        conv(8'h60);
        chk("throttle off", 32'h1, 32'(thermalThrottleN));
        chk("alert quiet", 32'h1, 32'(alertN));
        conv(8'h64);
        chk("alert again", 32'h0, 32'(alertN));
        bus(1'b0, thz_pkg::OFF_STATUS, 32'h0, 4'hf);
        chk("status cool", 32'h0, rdata);
        repeat (2) @(posedge core_clk);
        chk("alert released", 32'h1, 32'(alertN));
        conv(8'h68);
        chk("alert quiet", 32'h1, 32'(alertN));
        bus(1'b0, thz_pkg::OFF_EVENT, 32'h0, 4'hf);
        chk("events", 32'hf, rdata);
        bus(1'b1, thz_pkg::OFF_MASK, 32'h2, 4'hf);
        repeat (3) @(posedge core_clk);
        chk("irq on", 32'h1, 32'(irq));
        bus(1'b1, thz_pkg::OFF_EVENT, 32'h2, 4'hf);
        repeat (3) @(posedge core_clk);
        chk("irq cleared", 32'h0, 32'(irq));
        bus(1'b0, thz_pkg::OFF_EVENT, 32'h0, 4'hf);
        chk("events left", 32'hd, rdata);
        bus(1'b1, thz_pkg::OFF_MASK, 32'hf, 4'h0);
        bus(1'b0, thz_pkg::OFF_MASK, 32'h0, 4'hf);
        chk("mask kept", 32'h2, rdata);
        bus(1'b1, 5'h14, 32'hff, 4'hf);
        bus(1'b0, 5'h14, 32'h0, 4'hf);
        chk("unmapped", 32'h0, rdata);
        bus(1'b1, thz_pkg::OFF_CTRL, 32'h0, 4'hf);
        // The source and the start pulse stop one edge after the write lands.
        @(posedge core_clk);
        n = 0;
        repeat (100)
        begin
            @(posedge core_clk);
            if (ntcSourceEn !== 1'b0 || adcStart !== 1'b0)
                n++;
        end
        chk("stopped source", 32'h0, 32'(n));
        bus(1'b1, thz_pkg::OFF_CTRL, 32'h1, 4'hf);
        conv(8'h54);
        chk("hot throttle", 32'h0, 32'(thermalThrottleN));
        rst <= 1'b1;
        repeat (3) @(posedge core_clk);
        chk("reset throttle", 32'h1, 32'(thermalThrottleN));
        chk("reset irq", 32'h0, 32'(irq));
        rst <= 1'b0;
        bus(1'b0, thz_pkg::OFF_ZONE, 32'h0, 4'hf);
        chk("reset zone", 32'h0, rdata);
        bus(1'b0, thz_pkg::OFF_MASK, 32'h0, 4'hf);
        chk("reset mask", 32'h0, rdata);
        give_verdict();
    end
endmodule

`default_nettype wire

// [tb/thz_adc_model.sv]
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------------------------------
// Converter and thermistor network behind the sense pin
// ----------------------------------------------------------------
module thz_adc_model (
    input  wire logic       core_clk,
    input  wire logic       ntcSourceEn,
    input  wire logic       adcStart,
    input  wire logic [7:0] pinCode,
    input  wire logic       slowAdc,
    output var  logic       adcDone,
    output var  logic [7:0] adcCode
);
    // With the source off the pin sits at 0 V, the hottest zone, so a
    // sample taken at the wrong moment shows up in the zone code.
    initial
    begin
        adcDone = 1'b0;
        adcCode = 8'haa;
        forever
        begin
            @(posedge core_clk);
            if (adcStart === 1'b1)
            begin
                repeat (slowAdc ? 9 : 1) @(posedge core_clk);
                adcCode <= ntcSourceEn ? pinCode : 8'h00;
                repeat (3) @(posedge core_clk);
                adcDone <= 1'b1;
                repeat (4) @(posedge core_clk);
                adcDone <= 1'b0;
                @(posedge core_clk);
                // Hold time is over, so a stale code must not look valid.
                adcCode <= ~adcCode;
            end
        end
    end
endmodule

`default_nettype wire
